// ### cafc_filter_ctrl.sv
// apb register block holding the two can acceptance filter settings
//
// Behaviour
// [RL1] one enable bit per filter, bits 15/7
// [RL2] two-bit mask choice, bits 14-13 and 6-5
// [RL3] five-bit fifo target names fifo 0..31
// [RL4] fifo targets at bits 12-8 and 4-0
// [RL5] mask and target fields change only while filter disabled
// [RL6] reset clears every enable, mask, target field
module cafc_filter_ctrl #(
    parameter int ADDR_WIDTH = 12 // apb address bits decoded
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // apb slave request
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [ADDR_WIDTH-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    // apb slave answer
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // settings towards the receive engine
    output cafc_pkg::cafc_filter_t FILTER0_OUT,
    output cafc_pkg::cafc_filter_t FILTER1_OUT
);

    // ==========================================================
    // elaboration checks
    // ==========================================================
    // the decode compares whole offsets, so narrower buses cannot reach them
    if (ADDR_WIDTH < cafc_pkg::OFFSET_WIDTH) begin : g_bad_width
        $error("cafc_filter_ctrl: ADDR_WIDTH too small for register map");
    end

    // ==========================================================
    // declarations
    // ==========================================================
    localparam logic [ADDR_WIDTH-1:0] CONTROL_ADDR =
        ADDR_WIDTH'(cafc_pkg::FILTER_CONTROL_OFFSET); // control word
    localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR =
        ADDR_WIDTH'(cafc_pkg::FILTER_STATUS_OFFSET); // status word

    cafc_pkg::cafc_filter_t setting [cafc_pkg::NUM_FILTERS]; // live settings
    logic [cafc_pkg::NUM_FILTERS-1:0] lane_write; // per-filter write strobe
    logic [cafc_pkg::NUM_FILTERS-1:0] refused; // locked write attempt
    logic [cafc_pkg::STATUS_WIDTH-1:0] refused_flags; // sticky refused flags
    logic [cafc_pkg::STATUS_WIDTH-1:0] next_refused_flags; // flags after this edge
    logic hit_control; // address selects control word
    logic hit_status; // address selects status word
    logic hit_any; // address is mapped
    logic setup_phase; // first cycle of a transfer
    logic access_phase; // completing cycle of a transfer
    logic write_control; // control word written this edge
    logic write_status; // status word written this edge
    logic [31:0] control_word; // assembled control read value
    logic [31:0] status_word; // assembled status read value
    logic [31:0] next_rdata; // read value captured at setup

    // ==========================================================
    // address decode and phases
    // ==========================================================
    assign hit_control = (PADDR_IN == CONTROL_ADDR);
    assign hit_status = (PADDR_IN == STATUS_ADDR);
    assign hit_any = hit_control || hit_status;
    assign setup_phase = PSEL_IN && !PENABLE_IN;
    assign access_phase = PSEL_IN && PENABLE_IN;

    // zero wait states: every access completes in its first access cycle
    assign PREADY_OUT = 1'b1;
    // unmapped addresses answer with an error, writes there are dropped
    assign PSLVERR_OUT = access_phase && !hit_any;

    assign write_control = access_phase && PWRITE_IN && hit_control;
    assign write_status = access_phase && PWRITE_IN && hit_status && PSTRB_IN[0];

    // ==========================================================
    // filter slots, one byte lane each
    // ==========================================================
    // lane n of the word belongs to filter n: 7:0 filter 0, 15:8 filter 1
    for (genvar g = 0; g < cafc_pkg::NUM_FILTERS; g++) begin : g_slot
        assign lane_write[g] = write_control && PSTRB_IN[g];
        cafc_filter_slot u_slot (
            .clk_in(CLK_IN),
            .reset_in(RESET_IN),
            .write_in(lane_write[g]),
            .wdata_in(PWDATA_IN[g*cafc_pkg::LANE_WIDTH +: cafc_pkg::LANE_WIDTH]), // RL4
            .setting_out(setting[g]),
            .refused_out(refused[g])
        );
    end

    // settings straight from the slot flip-flops
    assign FILTER0_OUT = setting[0];
    assign FILTER1_OUT = setting[1];

    // ==========================================================
    // read value assembly
    // ==========================================================
    // upper half reads as zero: only filters 0 and 1 live here
    assign control_word = {16'h0000, setting[1], setting[0]}; // RL4
    assign status_word = {30'h0000_0000, refused_flags};

    always_comb begin
        next_rdata = cafc_pkg::RDATA_RESET;
        if (hit_control) begin
            next_rdata = control_word;
        end else if (hit_status) begin
            next_rdata = status_word;
        end
    end

    // ==========================================================
    // read data register
    // ==========================================================
    // captured in the setup cycle; only this bus can change the fields,
    // so the value still holds when the access phase completes
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            PRDATA_OUT <= cafc_pkg::RDATA_RESET;
        end else if (setup_phase && !PWRITE_IN) begin
            PRDATA_OUT <= next_rdata;
        end else if (setup_phase) begin
            PRDATA_OUT <= cafc_pkg::RDATA_RESET; // writes return zero
        end
    end

    // ==========================================================
    // refused-write flags
    // ==========================================================
    // write one to clear; a refusal in the same cycle wins over the clear
    always_comb begin
        next_refused_flags = refused_flags;
        if (write_status) begin
            next_refused_flags = refused_flags & ~PWDATA_IN[cafc_pkg::STATUS_WIDTH-1:0];
        end
        next_refused_flags = next_refused_flags | refused;
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            refused_flags <= cafc_pkg::STATUS_RESET;
        end else begin
            refused_flags <= next_refused_flags; // RL5
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    a_ready_every_access: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        access_phase |-> PREADY_OUT)
        else $error("access phase without ready");
    a_unmapped_error: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        access_phase && !hit_any |-> PSLVERR_OUT)
        else $error("unmapped access did not report an error");
    a_control_read_value: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RL4
        setup_phase && !PWRITE_IN && hit_control |=>
            PRDATA_OUT[15:0] == {$past(setting[1]), $past(setting[0])} &&
            PRDATA_OUT[31:16] == 16'h0000)
        else $error("control read returned wrong value");
    a_refused_flag_sets: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RL5
        refused[0] |=> refused_flags[0])
        else $error("refused write not flagged");
    a_flag_w1c_clears: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        write_status && PWDATA_IN[1] && !refused[1] |=> !refused_flags[1])
        else $error("status flag not cleared by write one");
    a_enable_bit_placed: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RL1
        write_control && PSTRB_IN[1] |=> FILTER1_OUT.enable == $past(PWDATA_IN[15]))
        else $error("filter 1 enable not at bit 15");
    a_mask_bits_placed: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RL2
        write_control && PSTRB_IN[0] && !FILTER0_OUT.enable |=>
            FILTER0_OUT.mask_choice == $past(PWDATA_IN[6:5]))
        else $error("filter 0 mask choice not at bits 6-5");
    a_target_bits_placed: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RL4
        write_control && PSTRB_IN[1] && !FILTER1_OUT.enable |=>
            FILTER1_OUT.fifo_target == $past(PWDATA_IN[12:8]))
        else $error("filter 1 fifo target not at bits 12-8");
    a_enable0_bit_placed: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RL1
        write_control && PSTRB_IN[0] |=> FILTER0_OUT.enable == $past(PWDATA_IN[7]))
        else $error("filter 0 enable not at bit 7");
    a_mask1_bits_placed: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RL2
        write_control && PSTRB_IN[1] && !FILTER1_OUT.enable |=>
            FILTER1_OUT.mask_choice == $past(PWDATA_IN[14:13]))
        else $error("filter 1 mask choice not at bits 14-13");
    a_target0_bits_placed: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RL4
        write_control && PSTRB_IN[0] && !FILTER0_OUT.enable |=>
            FILTER0_OUT.fifo_target == $past(PWDATA_IN[4:0]))
        else $error("filter 0 fifo target not at bits 4-0");
    // the receive engine must never see a live filter's routing move
    a_live_fields_kept: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RL5
        write_control && PSTRB_IN[1] && FILTER1_OUT.enable |=>
            $stable(FILTER1_OUT.mask_choice) && $stable(FILTER1_OUT.fifo_target))
        else $error("live filter 1 fields changed");
    a_refused1_flag_sets: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RL5
        refused[1] |=> refused_flags[1])
        else $error("refused write to filter 1 not flagged");
    a_status_read_value: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        setup_phase && !PWRITE_IN && hit_status |=>
            PRDATA_OUT == {30'h0000_0000, $past(refused_flags)})
        else $error("status read returned wrong value");
    a_unmapped_reads_zero: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        setup_phase && !PWRITE_IN && !hit_any |=> PRDATA_OUT == cafc_pkg::RDATA_RESET)
        else $error("unmapped read did not return zero");
    // flags move only on a refusal or a status write
    a_flags_hold_idle: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        !write_status && refused == '0 |=> $stable(refused_flags))
        else $error("refused flags changed without cause");

    c_write_accepted: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
        write_control && PSTRB_IN[0] && !FILTER0_OUT.enable);
    c_write_refused: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
        refused[1]);
    c_flag_cleared: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
        write_status && (refused_flags != cafc_pkg::STATUS_RESET));
    c_unmapped_access: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
        PSLVERR_OUT);

endmodule // cafc_filter_ctrl

// ### cafc_pkg.sv
// shared constants and types for the acceptance filter control block
package cafc_pkg;

    // ==========================================================
    // register map (byte addresses on the apb bus)
    // ==========================================================
    localparam int OFFSET_WIDTH = 12; // bits of address decoded
    localparam logic [11:0] FILTER_CONTROL_OFFSET = 12'h000; // can_filter_control_0
    localparam logic [11:0] FILTER_STATUS_OFFSET = 12'h004; // refused-write flags

    // ==========================================================
    // filter count and lane layout
    // ==========================================================
    localparam int NUM_FILTERS = 2; // filters 0 and 1 share one word
    localparam int LANE_WIDTH = 8; // one byte lane per filter
    localparam int ENABLE_POS = 7; // enable bit inside a lane
    localparam int MASK_LSB = 5; // mask choice low bit inside a lane
    localparam int MASK_WIDTH = 2; // four acceptance masks
    localparam int TARGET_LSB = 0; // fifo target low bit inside a lane
    localparam int TARGET_WIDTH = 5; // 32 receive fifos
    localparam int STATUS_WIDTH = 2; // one refused flag per filter

    // ==========================================================
    // carrier of one filter's settings
    // ==========================================================
    typedef struct packed {
        logic enable; // filter takes part in acceptance
        logic [1:0] mask_choice; // selects acceptance mask 0..3
        logic [4:0] fifo_target; // receive fifo that stores matches
    } cafc_filter_t;

    // all fields cleared: disabled, mask 0, fifo 0
    localparam cafc_filter_t FILTER_RESET = '{enable: 1'b0, mask_choice: 2'h0,
                                              fifo_target: 5'h00};
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000; // idle read data
    localparam logic [1:0] STATUS_RESET = 2'h0; // no refused write seen

endpackage : cafc_pkg

// ### cafc_filter_slot.sv
// one acceptance filter's enable, mask choice and fifo target fields
module cafc_filter_slot (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // write from the bus slave
    input wire logic write_in,
    input wire logic [7:0] wdata_in,
    // settings and refusal indication
    output cafc_pkg::cafc_filter_t setting_out,
    output logic refused_out
);

    // ==========================================================
    // lane decode
    // ==========================================================
    logic next_enable; // enable bit carried by the write
    logic [1:0] next_mask; // mask choice carried by the write
    logic [4:0] next_target; // fifo target carried by the write

    assign next_enable = wdata_in[cafc_pkg::ENABLE_POS];
    assign next_mask = wdata_in[cafc_pkg::MASK_LSB +: cafc_pkg::MASK_WIDTH];
    assign next_target = wdata_in[cafc_pkg::TARGET_LSB +: cafc_pkg::TARGET_WIDTH];

    // ==========================================================
    // enable bit: always writable so software can switch off
    // ==========================================================
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            setting_out.enable <= cafc_pkg::FILTER_RESET.enable; // RL6
        end else if (write_in) begin
            setting_out.enable <= next_enable; // RL1
        end
    end

    // ==========================================================
    // mask and target: locked while the filter is live
    // ==========================================================
    // the lock looks at the enable before the write, so a write that
    // turns the filter on may also load its fields in the same cycle
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            setting_out.mask_choice <= cafc_pkg::FILTER_RESET.mask_choice; // RL6
            setting_out.fifo_target <= cafc_pkg::FILTER_RESET.fifo_target; // RL6
        end else if (write_in && !setting_out.enable) begin
            setting_out.mask_choice <= next_mask; // RL2
            setting_out.fifo_target <= next_target; // RL3
        end
    end

    // a write that tries to change locked fields is flagged
    assign refused_out = write_in && setting_out.enable &&
                         ({next_mask, next_target} !=
                          {setting_out.mask_choice, setting_out.fifo_target}); // RL5

    // ==========================================================
    // checks
    // ==========================================================
    a_fields_locked_on: assert property (@(posedge clk_in) disable iff (reset_in) // RL5
        write_in && setting_out.enable |=> $stable(setting_out.mask_choice) &&
            $stable(setting_out.fifo_target))
        else $error("locked filter fields changed");
    a_fields_take_write: assert property (@(posedge clk_in) disable iff (reset_in) // RL3
        write_in && !setting_out.enable |=> setting_out.fifo_target == $past(next_target) &&
            setting_out.mask_choice == $past(next_mask))
        else $error("unlocked filter fields missed a write");
    a_enable_follows_write: assert property (@(posedge clk_in) disable iff (reset_in) // RL1
        write_in |=> setting_out.enable == $past(next_enable))
        else $error("enable bit did not follow write");
    a_fields_hold_idle: assert property (@(posedge clk_in) disable iff (reset_in) // RL2
        !write_in |=> $stable(setting_out))
        else $error("filter setting changed without a write");
    a_reset_all_zero: assert property (@(posedge clk_in) // RL6
        $fell(reset_in) |-> setting_out == cafc_pkg::FILTER_RESET)
        else $error("filter setting not cleared by reset");

endmodule // cafc_filter_slot

// ### cafc_rx_model.sv
// receive engine stand-in that routes a matched frame through the filter settings
module cafc_rx_model (
    // settings from the register block
    input cafc_pkg::cafc_filter_t filter0_in,
    input cafc_pkg::cafc_filter_t filter1_in,
    // which filters the incoming identifier matched
    input wire logic [1:0] hit_in,
    // routing decision
    output logic accept_out,
    output logic [1:0] mask_out,
    output logic [4:0] fifo_out
);
    // ==========================================================
    // routing
    // ==========================================================
    // filter 0 wins a double match; a disabled filter never routes
    always_comb begin
        accept_out = 1'b0;
        mask_out = 2'h0;
        fifo_out = 5'h00;
        if (hit_in[0] && filter0_in.enable) begin
            accept_out = 1'b1;
            mask_out = filter0_in.mask_choice;
            fifo_out = filter0_in.fifo_target;
        end else if (hit_in[1] && filter1_in.enable) begin
            accept_out = 1'b1;
            mask_out = filter1_in.mask_choice;
            fifo_out = filter1_in.fifo_target;
        end
    end
endmodule // cafc_rx_model

// ### can_acceptance_filter_control_tb.sv
// self-checking bench for the acceptance filter control register block
module can_acceptance_filter_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // bench signals
    // ==========================================================
    logic clk, rst, psel, pen, pwr, pready, pslverr, er, acc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [1:0] hit, msel;
    logic [4:0] fifo;
    cafc_pkg::cafc_filter_t f0, f1;
    int err_total, check_count;
    localparam logic [11:0] CTRL = cafc_pkg::FILTER_CONTROL_OFFSET;
    localparam logic [11:0] STAT = cafc_pkg::FILTER_STATUS_OFFSET;

    cafc_filter_ctrl dut (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .FILTER0_OUT(f0), .FILTER1_OUT(f1));
    cafc_rx_model rx (.filter0_in(f0), .filter1_in(f1), .hit_in(hit), .accept_out(acc),
        .mask_out(msel), .fifo_out(fifo));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (err_total == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // one apb transfer; an idle cycle follows so strobes never toggle twice in a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    // everything starts cleared
    task automatic t_reset;
        chk({24'h0, f0}, 32'h0000_0000);
        chk({24'h0, f1}, 32'h0000_0000);
        rdchk(CTRL, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0000);
    endtask

    // every mask code and fifo boundary in both lanes, upper half ignored
    task automatic t_fields;
        logic [4:0] f;
        logic [31:0] w;
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 3; k++) begin
                f = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : 5'(m * 7 + 3);
                w = {16'hFFFF, 1'b0, 2'(3 - m), 5'h1F - f, 1'b0, 2'(m), f};
                apb(1'b1, CTRL, w);
                chk({24'h0, f0}, {24'h0, w[7:0]});
                chk({24'h0, f1}, {24'h0, w[15:8]});
                rdchk(CTRL, {16'h0, w[15:0]});
            end
        end
    endtask

    // enabled filter refuses field changes; the enable itself stays writable
    task automatic t_lock;
        int sh;
        for (int i = 0; i < 2; i++) begin
            sh = i * 8;
            apb(1'b1, CTRL, 32'hD1 << sh);
            apb(1'b1, CTRL, 32'h85 << sh);
            rdchk(CTRL, 32'hD1 << sh);
            rdchk(STAT, 32'h1 << i);
            hit <= 2'(1 << i);
            @(posedge clk);
            chk({24'h0, acc, msel, fifo}, {24'h0, 1'b1, 2'h2, 5'h11});
            apb(1'b1, STAT, 32'h0000_0003);
            rdchk(STAT, 32'h0000_0000);
            apb(1'b1, CTRL, 32'h05 << sh);
            rdchk(CTRL, 32'h51 << sh);
            chk({31'h0, acc}, 32'h0000_0000);
            // the disabling write carried other fields, so it is flagged as well
            rdchk(STAT, 32'h1 << i);
            apb(1'b1, STAT, 32'h0000_0003);
            apb(1'b1, CTRL, 32'h05 << sh);
            rdchk(CTRL, 32'h05 << sh);
            hit <= 2'h0;
        end
    endtask

    // unmapped word: error answer, nothing stored, reads zero
    task automatic t_unmapped;
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h0000_0001);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        rdchk(CTRL, 32'h0000_0500);
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        err_total = 0;
        check_count = 0;
        rst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        hit = 2'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_fields();
        t_lock();
        t_unmapped();
        results();
    end
endmodule // can_acceptance_filter_control_tb
